// file: hdl/ssc_params.svh
/*
  Offsets, bit positions, reset values and fixed codes of the system status and
  control ports. Assumes a 10-bit I/O address; higher address lines wrap away outside.
*/
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------------------
`define SSC_ADDR_PRIMARY 10'h060
`define SSC_ADDR_CONTROL 10'h061
`define SSC_ADDR_SECONDARY 10'h062
`define SSC_ADDR_STATUS_WR 10'h064
`define SSC_ADDR_RAMFIT_WR 10'h065
`define SSC_ADDR_NMI_EN 10'h0a0

// ----------------------------------------------------------------------------
// Control port and NMI enable port bit positions
// ----------------------------------------------------------------------------
`define SSC_CTRL_KBD_SEL 7
`define SSC_CTRL_KBD_CLK_EN 6
`define SSC_CTRL_EXT_BLOCK 5
`define SSC_CTRL_PAR_DIS 4
`define SSC_CTRL_NIBBLE 2
`define SSC_CTRL_SPK 1
`define SSC_CTRL_GATE2 0
`define SSC_NMI_EN_BIT 7

// ----------------------------------------------------------------------------
// Reset values, masks and fixed codes
// ----------------------------------------------------------------------------
`define SSC_CTRL_RESET 8'h00
`define SSC_NMI_EN_RESET 1'b0
`define SSC_STATUS_WR_RESET 8'h00
`define SSC_RAMFIT_RESET 5'h00
`define SSC_STATUS_WR_MASK 8'h72
`define SSC_STATUS_FIXED 8'h0d
`define SSC_UNMAPPED_READ 8'hff
`define SSC_DISPLAY_MONO_80X25 2'h3
`define SSC_TIMER01_GATE_ON 2'h3

`endif

// file: hdl/ssc_pkg.sv
/*
  Types shared by the system status and control ports.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ssc_pkg;

  // --------------------------------------------------------------------------
  // Address decode result, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    SEL_NONE = 7'h01,
    SEL_PRIMARY = 7'h02,
    SEL_CONTROL = 7'h04,
    SEL_SECONDARY = 7'h08,
    SEL_STATUS_WR = 7'h10,
    SEL_RAMFIT_WR = 7'h20,
    SEL_NMI_EN = 7'h40
  } port_sel_type;

endpackage
`default_nettype wire

// file: hdl/system_status_control_ports.sv
/*
  System status and control ports: control port, two status ports, the
  status and RAM-fitted write registers, the NMI enable, keyboard code latch,
  NMI gating and speaker gating. Assumes one-cycle read and write strobes
  synchronous to clk_sys, and a keyboard receiver that delivers a whole code
  with a one-cycle valid pulse.
*/
//
// What this block does
// - Write-only NMI enable; bit 7 passes NMI, bit 7 clear blocks it.
// - Reset clears the NMI enable.
// - NMI combines on-board parity failure, coprocessor interrupt and channel-check.
// - Port directions are fixed; reset never changes them.
// - Control port holds select, clock enable, blocks, nibble, speaker and gate bits.
// - Select high reads status and disables keyboard; low reads keycode.
// - Each keycode arriving with clock enabled, select low and none pending is latched and raises the level 1 keyboard interrupt.
// - Keyboard data held low while interrupt pends; keyboard waits for release.
// - External block bit stops channel-check NMI and suppresses pending NMI.
// - NMI stays latched until software pulses the external block bit.
// - Nibble select picks low four RAM-fitted bits or its top bit.
// - Speaker is timer 2 output AND the speaker drive bit.
// - Control bit 0 drives timer 2 gate; gates 0 and 1 stay on.
// - Primary status: bit 7 zero, bits 3,2,0 one, others from register.
// - Display mode value three means external monochrome 80x25 text.
// - Secondary status: parity errors, timer 2 output, zero, RAM-fitted nibble.
// - Register at 064h supplies primary status bits 6, 5, 4 and 1.
// - Register at 065h holds the five RAM-fitted indicator bits.
// - On-board parity status bit reads zero while parity checking is disabled.
// - External parity status follows live input when blocked, else latched.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module system_status_control_ports (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic kbd_code_valid,
  input wire logic [7:0] kbd_code,
  output logic kbd_irq,
  output logic kbd_data_out,
  output logic kbd_data_oe,
  output logic kbd_clock_enable,
  input wire logic parity_error_in,
  input wire logic numeric_coprocessor_int,
  input wire logic channel_check_input,
  output logic nmi,
  input wire logic timer2_output,
  output logic timer2_gate,
  output logic [1:0] timer01_gate,
  output logic speaker_out,
  output logic [1:0] default_display_mode,
  output logic mono_80x25
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic ssc_pkg::port_sel_type decode_port(input logic [9:0] addr);
    case (addr)
      `SSC_ADDR_PRIMARY: decode_port = ssc_pkg::SEL_PRIMARY;
      `SSC_ADDR_CONTROL: decode_port = ssc_pkg::SEL_CONTROL;
      `SSC_ADDR_SECONDARY: decode_port = ssc_pkg::SEL_SECONDARY;
      `SSC_ADDR_STATUS_WR: decode_port = ssc_pkg::SEL_STATUS_WR;
      `SSC_ADDR_RAMFIT_WR: decode_port = ssc_pkg::SEL_RAMFIT_WR;
      `SSC_ADDR_NMI_EN: decode_port = ssc_pkg::SEL_NMI_EN;
      default: decode_port = ssc_pkg::SEL_NONE;
    endcase
  endfunction

  ssc_pkg::port_sel_type sel;

  assign sel = decode_port(io_addr);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic nmi_en_r;
  logic nmi_en_nxt;
  logic [7:0] status_wr_r;
  logic [7:0] status_wr_nxt;
  logic [4:0] ramfit_r;
  logic [4:0] ramfit_nxt;
  logic [7:0] kbd_code_r;
  logic [7:0] kbd_code_nxt;
  logic kbd_pend_r;
  logic kbd_pend_nxt;
  logic par_latch_r;
  logic par_latch_nxt;
  logic chk_latch_r;
  logic chk_latch_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [7:0] primary_status;
  logic [7:0] secondary_status;
  logic [3:0] ram_nibble;
  logic par_set;
  logic chk_set;

  // Port directions are structural: only the control and write registers
  // take bus data, so nothing at reset can turn a status port around.
  always_comb
  begin
    ram_nibble = ctrl_r[`SSC_CTRL_NIBBLE] ? ramfit_r[3:0] : {3'h0, ramfit_r[4]};
    primary_status = (status_wr_r & `SSC_STATUS_WR_MASK) | `SSC_STATUS_FIXED;
    secondary_status = {par_latch_r & ~ctrl_r[`SSC_CTRL_PAR_DIS],
                        ctrl_r[`SSC_CTRL_EXT_BLOCK] ? channel_check_input : chk_latch_r,
                        timer2_output,
                        1'b0,
                        ram_nibble};
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    nmi_en_nxt = nmi_en_r;
    status_wr_nxt = status_wr_r;
    ramfit_nxt = ramfit_r;
    if (io_wr)
    begin
      case (sel)
        ssc_pkg::SEL_CONTROL: ctrl_nxt = io_wdata;
        ssc_pkg::SEL_NMI_EN: nmi_en_nxt = io_wdata[`SSC_NMI_EN_BIT];
        ssc_pkg::SEL_STATUS_WR: status_wr_nxt = io_wdata & `SSC_STATUS_WR_MASK;
        ssc_pkg::SEL_RAMFIT_WR: ramfit_nxt = io_wdata[4:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  // Keyboard: a code arriving while one pends is dropped; the held data line
  // tells a well-behaved keyboard not to send it.
  always_comb
  begin
    kbd_code_nxt = kbd_code_r;
    kbd_pend_nxt = kbd_pend_r;
    if (ctrl_r[`SSC_CTRL_KBD_SEL])
    begin
      kbd_pend_nxt = 1'b0;
    end
    else if (kbd_code_valid && ctrl_r[`SSC_CTRL_KBD_CLK_EN] && !kbd_pend_r)
    begin
      kbd_code_nxt = kbd_code;
      kbd_pend_nxt = 1'b1;
    end
  end

  // NMI sources: a new parity fault in the clearing cycle keeps its latch set; a new channel-check fault does not.
  always_comb
  begin
    par_set = parity_error_in && !ctrl_r[`SSC_CTRL_PAR_DIS];
    chk_set = channel_check_input && !ctrl_r[`SSC_CTRL_EXT_BLOCK];
    par_latch_nxt = par_set || (par_latch_r && !ctrl_r[`SSC_CTRL_EXT_BLOCK]);
    chk_latch_nxt = chk_set || (chk_latch_r && !ctrl_r[`SSC_CTRL_EXT_BLOCK]);
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    rvalid_nxt = io_rd;
    if (io_rd)
    begin
      case (sel)
        ssc_pkg::SEL_PRIMARY: rdata_nxt = ctrl_r[`SSC_CTRL_KBD_SEL] ? primary_status : kbd_code_r;
        ssc_pkg::SEL_CONTROL: rdata_nxt = ctrl_r;
        ssc_pkg::SEL_SECONDARY: rdata_nxt = secondary_status;
        default: rdata_nxt = `SSC_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `SSC_CTRL_RESET;
      nmi_en_r <= `SSC_NMI_EN_RESET;
      status_wr_r <= `SSC_STATUS_WR_RESET;
      ramfit_r <= `SSC_RAMFIT_RESET;
      kbd_code_r <= 8'h00;
      kbd_pend_r <= 1'b0;
      par_latch_r <= 1'b0;
      chk_latch_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      nmi_en_r <= nmi_en_nxt;
      status_wr_r <= status_wr_nxt;
      ramfit_r <= ramfit_nxt;
      kbd_code_r <= kbd_code_nxt;
      kbd_pend_r <= kbd_pend_nxt;
      par_latch_r <= par_latch_nxt;
      chk_latch_r <= chk_latch_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign io_rdata = rdata_r;
  assign io_rvalid = rvalid_r;
  assign kbd_irq = kbd_pend_r && !ctrl_r[`SSC_CTRL_KBD_SEL];
  assign kbd_data_out = 1'b0;
  assign kbd_data_oe = kbd_pend_r;
  assign kbd_clock_enable = ctrl_r[`SSC_CTRL_KBD_CLK_EN];
  // The coprocessor line is level driven and not latched here.
  assign nmi = nmi_en_r && (numeric_coprocessor_int ||
               (!ctrl_r[`SSC_CTRL_EXT_BLOCK] && (par_latch_r || chk_latch_r)));
  assign speaker_out = timer2_output && ctrl_r[`SSC_CTRL_SPK];
  assign timer2_gate = ctrl_r[`SSC_CTRL_GATE2];
  assign timer01_gate = `SSC_TIMER01_GATE_ON;
  assign default_display_mode = status_wr_r[5:4];
  assign mono_80x25 = (status_wr_r[5:4] == `SSC_DISPLAY_MONO_80X25);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_nmi_blocked;
    @(posedge clk_sys) disable iff (!rst_n)
    !nmi_en_r |-> !nmi;
  endproperty
  a_nmi_blocked: assert property (p_nmi_blocked) else $error("nmi passed while disabled");

  property p_nmi_en_write;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && io_wr && sel == ssc_pkg::SEL_NMI_EN |=> nmi_en_r == $past(io_wdata[7]);
  endproperty
  a_nmi_en_write: assert property (p_nmi_en_write) else $error("nmi enable not written");

  property p_nmi_reset;
    @(posedge clk_sys)
    $rose(rst_n) |-> !nmi_en_r && !nmi;
  endproperty
  a_nmi_reset: assert property (p_nmi_reset) else $error("nmi enabled after reset");

  property p_chk_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && channel_check_input && !ctrl_r[5] |=> chk_latch_r [*2] or (ctrl_r[5] or !ce);
  endproperty
  a_chk_latch: assert property (p_chk_latch) else $error("channel check not latched");

  property p_block_clears;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ctrl_r[5] && !(parity_error_in && !ctrl_r[4])
      |=> !chk_latch_r && !(nmi && !numeric_coprocessor_int);
  endproperty
  a_block_clears: assert property (p_block_clears) else $error("blocked nmi survived");

  property p_kbd_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && kbd_code_valid && ctrl_r[6] && !ctrl_r[7] && !kbd_pend_r
      |=> kbd_data_oe && !kbd_data_out && kbd_code_r == $past(kbd_code);
  endproperty
  a_kbd_latch: assert property (p_kbd_latch) else $error("keycode not latched");

  property p_primary_read;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && io_rd && sel == ssc_pkg::SEL_PRIMARY
      |=> io_rvalid && io_rdata == ($past(ctrl_r[7]) ? (($past(status_wr_r) & 8'h72) | 8'h0d)
                                                     : $past(kbd_code_r));
  endproperty
  a_primary_read: assert property (p_primary_read) else $error("primary port wrong");

  property p_secondary_read;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && io_rd && sel == ssc_pkg::SEL_SECONDARY
      |=> io_rdata[5] == $past(timer2_output) && !io_rdata[4]
          && (!$past(ctrl_r[4]) || !io_rdata[7])
          && ($past(ctrl_r[2]) || io_rdata[3:0] == {3'h0, $past(ramfit_r[4])});
  endproperty
  a_secondary_read: assert property (p_secondary_read) else $error("secondary port wrong");

  property p_ctrl_readback;
    @(posedge clk_sys) disable iff (!rst_n)
    ce && io_wr && sel == ssc_pkg::SEL_CONTROL ##1 !io_wr
      ##1 ce && io_rd && sel == ssc_pkg::SEL_CONTROL
      |=> io_rdata == $past(io_wdata, 3);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

  property p_speaker;
    @(posedge clk_sys) disable iff (!rst_n)
    speaker_out == (timer2_output && ctrl_r[1]) && timer2_gate == ctrl_r[0] && timer01_gate == 2'h3;
  endproperty
  a_speaker: assert property (p_speaker) else $error("speaker or gate wrong");

endmodule
`default_nettype wire

// file: verification/ssc_host_model.sv
/*
  Host side of the status and control ports: byte I/O cycles and a keyboard
  code sender. Assumes one clk_sys domain; the bench calls the tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
  input wire logic clk_sys,
  output logic [9:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  output logic kbd_code_valid,
  output logic [7:0] kbd_code,
  input wire logic kbd_data_oe,
  output logic late
);
  // ------------
  // Bus cycles
  // ------------
  initial
  begin
    io_addr = 10'h3ff;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    kbd_code_valid = 1'b0;
    kbd_code = 8'h00;
    late = 1'b0;
  end
  // Released lines show the inverse, so a stale value can never pass.
  task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
    int i;
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_addr <= ~a;
    d = 8'h00;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      if (io_rvalid === 1'b1)
        break;
    end
    if (i == 4)
      late = 1'b1;
    d = io_rdata;
  endtask
  // ------------
  // Keyboard
  // ------------
  // The keyboard sends only once the data line is let go.
  task automatic kbd_send(input logic [7:0] c);
    int i;
    for (i = 0; i < 50 && kbd_data_oe !== 1'b0; i++)
      @(posedge clk_sys);
    if (i == 50)
      late = 1'b1;
    @(posedge clk_sys);
    kbd_code <= c;
    kbd_code_valid <= 1'b1;
    @(posedge clk_sys);
    kbd_code_valid <= 1'b0;
    kbd_code <= ~c;
  endtask
endmodule
`default_nettype wire

// file: verification/system_status_control_ports_tb.sv
/*
  Self-checking bench for the system status and control ports.
  Assumes the host model file and ssc_params.svh are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module system_status_control_ports_tb;
  logic clk_sys, arst_n, rvalid, wr, rd, kv, irq, oe, ken, dout, nmi, t2, gate2, spk, mono;
  logic par, cop, chk, late, ce;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, kcode;
  logic [1:0] g01, ddm;
  int n_mismatch = 0;
  int num_checks = 0;
  // ------------
  // Clock, parts
  // ------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ssc_host_model host_u (.clk_sys(clk_sys), .io_addr(addr), .io_wr(wr), .io_rd(rd),
    .io_wdata(wdata), .io_rdata(rdata), .io_rvalid(rvalid), .kbd_code_valid(kv),
    .kbd_code(kcode), .kbd_data_oe(oe), .late(late));
  system_status_control_ports dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .io_addr(addr), .io_wr(wr), .io_rd(rd), .io_wdata(wdata), .io_rdata(rdata),
    .io_rvalid(rvalid), .kbd_code_valid(kv), .kbd_code(kcode), .kbd_irq(irq),
    .kbd_data_out(dout), .kbd_data_oe(oe), .kbd_clock_enable(ken),
    .parity_error_in(par), .numeric_coprocessor_int(cop), .channel_check_input(chk),
    .nmi(nmi), .timer2_output(t2), .timer2_gate(gate2), .timer01_gate(g01),
    .speaker_out(spk), .default_display_mode(ddm), .mono_80x25(mono));
  // ------------
  // Helpers
  // ------------
  task automatic wr_b(input logic [9:0] a, input logic [7:0] d);
    host_u.bus_wr(a, d);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] got;
    host_u.bus_rd(a, got);
    `CHECK(got, e)
  endtask
  task automatic give_verdict;
    if (late === 1'b1)
      n_mismatch++;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge late) give_verdict;
  // ------------
  // Scenarios
  // ------------
  task automatic t_reset_state;
    rd_chk(`SSC_ADDR_CONTROL, 8'h00);
    `CHECK(nmi, 1'b0)
    `CHECK(g01, 2'h3)
    rd_chk(`SSC_ADDR_NMI_EN, 8'hff);
  endtask
  task automatic t_control;
    t2 <= 1'b1;
    wr_b(`SSC_ADDR_CONTROL, 8'h03);
    `CHECK(gate2, 1'b1)
    `CHECK(spk, 1'b1)
    host_u.bus_wr(`SSC_ADDR_CONTROL, 8'h01);
    rd_chk(`SSC_ADDR_CONTROL, 8'h01);
    `CHECK(spk, 1'b0)
    ce <= 1'b0;
    host_u.bus_wr(`SSC_ADDR_CONTROL, 8'h02);
    ce <= 1'b1;
    rd_chk(`SSC_ADDR_CONTROL, 8'h01);
    rd_chk(10'h063, 8'hff);
  endtask
  task automatic t_status;
    wr_b(`SSC_ADDR_STATUS_WR, 8'hff);
    wr_b(`SSC_ADDR_PRIMARY, 8'h00);
    wr_b(`SSC_ADDR_CONTROL, 8'h80);
    rd_chk(`SSC_ADDR_PRIMARY, 8'h7f);
    `CHECK(mono, 1'b1)
    wr_b(`SSC_ADDR_STATUS_WR, 8'h20);
    rd_chk(`SSC_ADDR_PRIMARY, 8'h2d);
    `CHECK(ddm, 2'h2)
  endtask
  task automatic t_ramfit;
    wr_b(`SSC_ADDR_RAMFIT_WR, 8'h12);
    wr_b(`SSC_ADDR_CONTROL, 8'h84);
    rd_chk(`SSC_ADDR_SECONDARY, 8'h22);
    wr_b(`SSC_ADDR_CONTROL, 8'h80);
    rd_chk(`SSC_ADDR_SECONDARY, 8'h21);
  endtask
  task automatic t_keyboard;
    wr_b(`SSC_ADDR_CONTROL, 8'h40);
    `CHECK(ken, 1'b1)
    host_u.kbd_send(8'ha5);
    repeat (2) @(posedge clk_sys);
    `CHECK({irq, oe, dout}, 3'b110)
    rd_chk(`SSC_ADDR_PRIMARY, 8'ha5);
    wr_b(`SSC_ADDR_CONTROL, 8'hc0);
    `CHECK({irq, oe}, 2'b00)
    rd_chk(`SSC_ADDR_PRIMARY, 8'h2d);
    wr_b(`SSC_ADDR_CONTROL, 8'h40);
    host_u.kbd_send(8'h3c);
    repeat (2) @(posedge clk_sys);
    rd_chk(`SSC_ADDR_PRIMARY, 8'h3c);
  endtask
  task automatic t_nmi;
    wr_b(`SSC_ADDR_CONTROL, 8'h00);
    wr_b(`SSC_ADDR_NMI_EN, 8'h80);
    chk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHECK(nmi, 1'b1)
    rd_chk(`SSC_ADDR_SECONDARY, 8'h61);
    wr_b(`SSC_ADDR_CONTROL, 8'h20);
    `CHECK(nmi, 1'b0)
    chk <= 1'b0;
    rd_chk(`SSC_ADDR_SECONDARY, 8'h21);
    wr_b(`SSC_ADDR_CONTROL, 8'h00);
    `CHECK(nmi, 1'b0)
    par <= 1'b1;
    @(posedge clk_sys);
    par <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHECK(nmi, 1'b1)
    rd_chk(`SSC_ADDR_SECONDARY, 8'ha1);
    wr_b(`SSC_ADDR_CONTROL, 8'h10);
    rd_chk(`SSC_ADDR_SECONDARY, 8'h21);
    wr_b(`SSC_ADDR_CONTROL, 8'h20);
    wr_b(`SSC_ADDR_CONTROL, 8'h00);
    `CHECK(nmi, 1'b0)
    cop <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHECK(nmi, 1'b1)
    wr_b(`SSC_ADDR_NMI_EN, 8'h7f);
    `CHECK(nmi, 1'b0)
    wr_b(`SSC_ADDR_NMI_EN, 8'h80);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHECK(nmi, 1'b0)
    cop <= 1'b0;
  endtask
  // ------------
  // Main sequence
  // ------------
  // Reset is released only after 20 edges so the synchroniser has settled.
  initial
  begin
    arst_n = 1'b0;
    {par, cop, chk, t2} = 4'h0;
    ce = 1'b1;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset_state();
    t_control();
    t_status();
    t_ramfit();
    t_keyboard();
    t_nmi();
    give_verdict();
  end
endmodule
`default_nettype wire
